// ==== logic/roc_output_control.sv ====
// Output control register with AHB-Lite slave and over-temperature latch
`timescale 1ns/10ps
`include "roc_consts.svh"
module roc_output_control (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Regulator side
    input wire logic overtemp_event_in,
    input wire logic power_down,
    output logic full_duty_allow,
    output logic forced_pwm_select,
    output logic light_load_mode,
    output logic output_discharge_enable,
    output logic [3:0] slew_code,
    output logic [15:0] slew_time_us,
    output logic regulator_latched_off
);
    // Address phase capture
    logic take;
    logic wr_pend_r;
    logic wr_pend_nxt;
    logic [`ROC_ADDR_BITS-1:0] addr_r;
    logic [`ROC_ADDR_BITS-1:0] addr_nxt;
    logic wr_hits_control;

    // Register and its registered decodes
    logic [7:0] output_control_r;
    logic [7:0] output_control_nxt;
    logic full_duty_allow_r;
    logic full_duty_allow_nxt;
    logic forced_pwm_r;
    logic forced_pwm_nxt;
    logic light_load_r;
    logic light_load_nxt;
    logic discharge_armed_r;
    logic discharge_armed_nxt;
    logic [3:0] slew_code_r;
    logic [3:0] slew_code_nxt;
    logic [15:0] slew_time_r;
    logic [15:0] slew_time_nxt;

    // Read data
    logic [31:0] hrdata_r;
    logic [31:0] hrdata_nxt;
    logic rd_take;

    // Over-temperature input path
    logic [1:0] ot_sync_r;
    logic [1:0] ot_sync_nxt;
    logic ot_prev_r;
    logic ot_prev_nxt;
    logic ot_rise;

    // Over-temperature latch-off state
    roc_pkg::roc_ot_state_t ot_state_r;
    roc_pkg::roc_ot_state_t ot_state_nxt;
    logic [2:0] ot_count_r;
    logic [2:0] ot_count_nxt;
    logic latched;

    // Step time grows linearly with the code
    function automatic logic [15:0] slew_us(input logic [3:0] code);
        slew_us = `ROC_SLEW_BASE_US + 16'(code) * `ROC_SLEW_STEP_US;
    endfunction

    // Address phase that this slave must act on
    function automatic logic is_taken(
        input logic sel,
        input logic rdy,
        input logic [1:0] trans
    );
        is_taken = sel && rdy && (trans == `ROC_HTRANS_NONSEQ);
    endfunction

    // Read value of the control word; upper bits read as zero
    function automatic logic [31:0] control_word(input logic [7:0] value);
        control_word = {24'h00_0000, value};
    endfunction

    // Read value of the status word
    function automatic logic [31:0] status_word(
        input logic [2:0] count,
        input logic lat
    );
        status_word = {29'h0000_0000, count} | {31'h0000_0000, lat};
    endfunction

    // Next event count, saturating at the latch threshold
    function automatic logic [2:0] count_up(input logic [2:0] count);
        if (count >= `ROC_OVERTEMP_LATCH_POLICY_COUNT) begin
            count_up = `ROC_OVERTEMP_LATCH_POLICY_COUNT;
        end else begin
            count_up = count + 3'h1;
        end
    endfunction

    assign take = is_taken(hsel, hready, htrans);
    assign rd_take = take && !hwrite;
    assign wr_hits_control = wr_pend_r && (addr_r == `ROC_ADDR_OUTPUT_CONTROL);

    always_comb begin
        wr_pend_nxt = take && hwrite;
        addr_nxt = addr_r;
        if (take) begin
            addr_nxt = haddr[`ROC_ADDR_BITS-1:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            addr_r <= '0;
        end else begin
            wr_pend_r <= wr_pend_nxt;
            addr_r <= addr_nxt;
        end
    end

    // Write lands at the end of its data phase; hsize is not decoded
    always_comb begin
        output_control_nxt = output_control_r;
        if (wr_hits_control) begin
            output_control_nxt = hwdata[7:0];
        end
        full_duty_allow_nxt = !output_control_nxt[`ROC_BIT_FULL_DUTY];
        forced_pwm_nxt = output_control_nxt[`ROC_BIT_FORCED_PWM_SELECT];
        light_load_nxt = !output_control_nxt[`ROC_BIT_FORCED_PWM_SELECT];
        discharge_armed_nxt = output_control_nxt[`ROC_BIT_DISCHARGE];
        slew_code_nxt = output_control_nxt[`ROC_SLEW_MSB:0];
        slew_time_nxt = slew_us(output_control_nxt[`ROC_SLEW_MSB:0]);
    end

    // Decodes share the register's edge, so outputs never lag the read-back
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            output_control_r <= `ROC_RESET_OUTPUT_CONTROL;
            full_duty_allow_r <= 1'b1;
            forced_pwm_r <= 1'b0;
            light_load_r <= 1'b1;
            discharge_armed_r <= 1'b0;
            slew_code_r <= 4'h0;
            slew_time_r <= `ROC_SLEW_BASE_US;
        end else begin
            output_control_r <= output_control_nxt;
            full_duty_allow_r <= full_duty_allow_nxt;
            forced_pwm_r <= forced_pwm_nxt;
            light_load_r <= light_load_nxt;
            discharge_armed_r <= discharge_armed_nxt;
            slew_code_r <= slew_code_nxt;
            slew_time_r <= slew_time_nxt;
        end
    end

    // A read right behind a write sees the new value
    always_comb begin
        hrdata_nxt = hrdata_r;
        if (rd_take) begin
            case (haddr[`ROC_ADDR_BITS-1:0])
                `ROC_ADDR_OUTPUT_CONTROL: begin
                    hrdata_nxt = control_word(output_control_nxt);
                end
                `ROC_ADDR_OVERTEMP_STATUS: begin
                    hrdata_nxt = status_word(ot_count_r, latched);
                end
                default: begin
                    hrdata_nxt = 32'h0000_0000;
                end
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_r <= 32'h0000_0000;
        end else begin
            hrdata_r <= hrdata_nxt;
        end
    end

    // Pin is asynchronous; only the second flop feeds the edge detector
    always_comb begin
        ot_sync_nxt = {ot_sync_r[0], overtemp_event_in};
        ot_prev_nxt = ot_sync_r[1];
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ot_sync_r <= 2'b00;
            ot_prev_r <= 1'b0;
        end else begin
            ot_sync_r <= ot_sync_nxt;
            ot_prev_r <= ot_prev_nxt;
        end
    end

    // Idle level is low, so no false edge follows reset
    assign ot_rise = ot_sync_r[1] && !ot_prev_r;
    assign latched = (ot_state_r == roc_pkg::ROC_OT_LATCHED);

    // Count survives a policy change; only power down while latched clears it
    always_comb begin
        ot_state_nxt = ot_state_r;
        ot_count_nxt = ot_count_r;
        case (ot_state_r)
            roc_pkg::ROC_OT_RUN: begin
                if (ot_rise) begin
                    if (!output_control_r[`ROC_BIT_OT_POLICY]) begin
                        ot_state_nxt = roc_pkg::ROC_OT_LATCHED;
                    end else if (count_up(ot_count_r) >= `ROC_OVERTEMP_LATCH_POLICY_COUNT) begin
                        ot_count_nxt = `ROC_OVERTEMP_LATCH_POLICY_COUNT;
                        ot_state_nxt = roc_pkg::ROC_OT_LATCHED;
                    end else begin
                        ot_count_nxt = count_up(ot_count_r);
                    end
                end
            end
            roc_pkg::ROC_OT_LATCHED: begin
                // Only a power cycle clears the latch
                if (power_down) begin
                    ot_state_nxt = roc_pkg::ROC_OT_RUN;
                    ot_count_nxt = 3'h0;
                end
            end
            default: begin
                ot_state_nxt = roc_pkg::ROC_OT_RUN;
                ot_count_nxt = 3'h0;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ot_state_r <= roc_pkg::ROC_OT_RUN;
            ot_count_r <= 3'h0;
        end else begin
            ot_state_r <= ot_state_nxt;
            ot_count_r <= ot_count_nxt;
        end
    end

    // Zero-wait slave, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_r;

    assign full_duty_allow = full_duty_allow_r;
    assign forced_pwm_select = forced_pwm_r;
    assign light_load_mode = light_load_r;
    // Gated by the power-down level so the pull-down acts in the same cycle
    assign output_discharge_enable = discharge_armed_r && power_down;
    assign slew_code = slew_code_r;
    assign slew_time_us = slew_time_r;
    assign regulator_latched_off = latched;
endmodule // roc_output_control

// ==== logic/roc_consts.svh ====
// Constants for the regulator output control register block
`ifndef ROC_CONSTS_SVH
`define ROC_CONSTS_SVH
`define ROC_IDX_OUTPUT_CONTROL 8'h01
`define ROC_ADDR_OUTPUT_CONTROL 12'h004
`define ROC_ADDR_OVERTEMP_STATUS 12'h008
`define ROC_ADDR_BITS 12
`define ROC_RESET_OUTPUT_CONTROL 8'h00
`define ROC_BIT_FULL_DUTY 7
`define ROC_BIT_FORCED_PWM_SELECT 6
`define ROC_BIT_OT_POLICY 5
`define ROC_BIT_DISCHARGE 4
`define ROC_SLEW_MSB 3
`define ROC_SLEW_BASE_US 16'h00C8
`define ROC_SLEW_STEP_US 16'h00C8
`define ROC_OVERTEMP_LATCH_POLICY_COUNT 3'h4
`define ROC_HTRANS_NONSEQ 2'h2
`endif

// ==== logic/roc_pkg.sv ====
// Types for the regulator output control register block
package roc_pkg;
    typedef enum logic [1:0] {
        ROC_OT_RUN = 2'b00,
        ROC_OT_LATCHED = 2'b01
    } roc_ot_state_t;
endpackage

// ==== bench/roc_checker.sv ====
// Port checker for the output control register
`timescale 1ns/10ps
module roc_checker (
    input wire logic hclk, hresetn, hwrite, hreadyout, hresp, power_down,
    input wire logic [1:0] htrans,
    input wire logic [31:0] haddr, hrdata,
    input wire logic full_duty_allow, forced_pwm_select, light_load_mode,
    input wire logic output_discharge_enable, regulator_latched_off,
    input wire logic [3:0] slew_code,
    input wire logic [15:0] slew_time_us
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    AST_DUTY: assert property ($changed(full_duty_allow) |-> $past(hwrite, 2))
        else $error("duty setting moved without a write");
    AST_MODE: assert property (forced_pwm_select != light_load_mode)
        else $error("mode outputs agree");
    AST_LATCH: assert property (regulator_latched_off && !power_down |=> regulator_latched_off)
        else $error("latch dropped");
    AST_DISCH: assert property (!power_down |-> !output_discharge_enable)
        else $error("discharge while powered");
    AST_SLEW: assert property (slew_time_us == 16'h00C8 + 16'h00C8 * slew_code)
        else $error("slew time wrong");
    AST_READ: assert property ($past(htrans) == 2'h2 && !$past(hwrite) && $past(haddr) == 32'h4
        |-> hrdata[7:6] == {!full_duty_allow, forced_pwm_select})
        else $error("readback differs");
    AST_BUS: assert property (hreadyout && !hresp)
        else $error("bus answer wrong");
endmodule // roc_checker

// ==== bench/roc_host_model.sv ====
// Host side bus master model
`timescale 1ns/10ps
module roc_host_model (
    input wire logic hclk,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    output logic hwrite = 1'b0,
    output logic [1:0] htrans = 2'h0,
    output logic [31:0] haddr = 32'h0000_0000,
    output logic [31:0] hwdata = 32'h0000_0000
);
    task automatic xfer(input logic w, input logic [31:0] a, d, output logic [31:0] r);
        @(posedge hclk);
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        r = hrdata;
    endtask
endmodule // roc_host_model

// ==== bench/tb_regulator_output_control_reg.sv ====
// Bench for the output control register
`timescale 1ns/10ps
module tb_regulator_output_control_reg;
    logic hclk = 0, hresetn = 0, ot = 0, pd = 0, hwrite, hrd, hrs, fda, fps, llm, ode, lat;
    logic [1:0] htrans;
    logic [3:0] sc;
    logic [15:0] st;
    logic [31:0] haddr, hwdata, hrdata, r;
    int failures = 0, check_count = 0;
    roc_host_model i_roc_host_model (.hclk(hclk), .hready(hrd), .hrdata(hrdata),
        .hwrite(hwrite), .htrans(htrans), .haddr(haddr), .hwdata(hwdata));
    roc_output_control i_roc_output_control (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hrd),
        .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hrd), .hresp(hrs),
        .overtemp_event_in(ot), .power_down(pd), .full_duty_allow(fda),
        .forced_pwm_select(fps), .light_load_mode(llm), .output_discharge_enable(ode),
        .slew_code(sc), .slew_time_us(st), .regulator_latched_off(lat));
    task automatic chk(input logic [31:0] got, exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic t_fields();
        logic [7:0] v;
        for (int i = 0; i < 16; i++) begin
            v = {i[3:0], 4'hF - i[3:0]};
            i_roc_host_model.xfer(1'b1, 32'h4, {24'h0, v}, r);
            i_roc_host_model.xfer(1'b0, 32'h4, 32'h0, r);
            chk(r, {24'h0, v});
            chk(fda, !v[7]);
            chk({fps, llm}, {v[6], !v[6]});
            chk(st, 16'h00C8 + 16'h00C8 * v[3:0]);
            chk(sc, v[3:0]);
            @(posedge hclk) pd <= 1'b1;
            @(posedge hclk) chk(ode, v[4]);
            pd <= 1'b0;
        end
    endtask
    task automatic t_ot(input logic pol);
        i_roc_host_model.xfer(1'b1, 32'h4, {26'h0, pol, 5'h0}, r);
        @(posedge hclk) pd <= 1'b1;
        @(posedge hclk) pd <= 1'b0;
        for (int k = 1; k < 5; k++) begin
            repeat (4) @(posedge hclk) ot <= 1'b1;
            repeat (4) @(posedge hclk) ot <= 1'b0;
            chk(lat, !pol || k == 4);
        end
        i_roc_host_model.xfer(1'b0, 32'h8, 32'h0, r);
        chk(r, pol ? 32'h5 : 32'h1);
    endtask
    task automatic end_of_test();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial forever #10 hclk = ~hclk;
    initial begin
        #200_000 failures++;
        end_of_test();
    end
    initial begin
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        i_roc_host_model.xfer(1'b0, 32'h4, 32'h0, r);
        chk({r[7:0], fda, st}, {8'h00, 1'b1, 16'h00C8});
        i_roc_host_model.xfer(1'b0, 32'h10, 32'h0, r);
        chk(r, 32'h0);
        t_fields();
        t_ot(1'b0);
        t_ot(1'b1);
        end_of_test();
    end
endmodule // tb_regulator_output_control_reg
bind roc_output_control roc_checker i_roc_checker (.*);
